// file: shared/oms_consts.vh
`ifndef OMS_CONSTS_VH
`define OMS_CONSTS_VH

// ****************************************
// Parameter addresses on the parameter port, for writes and reads
// ****************************************
`define OMS_ADDR_MODE_SEL   16'h1B06
`define OMS_ADDR_CUR_REF    16'h1B20
`define OMS_ADDR_CUR_SET    16'h2008

// ****************************************
// Reset values
// ****************************************
`define OMS_RST_MODE        16'h0000
`define OMS_RST_CUR_REF     16'h0000
`define OMS_RST_CUR_SET     16'h0000

// ****************************************
// Mode codes (signed 16 bit)
// ****************************************
`define OMS_MODE_NONE       16'h0000
`define OMS_MODE_PROF_POS   16'h0001
`define OMS_MODE_PROF_VEL   16'h0003
`define OMS_MODE_HOMING     16'h0006
`define OMS_MODE_JOG        16'hFFFF
`define OMS_MODE_GEAR       16'hFFFE
`define OMS_MODE_CURRENT    16'hFFFD
`define OMS_MODE_SPEED      16'hFFFC
`define OMS_MODE_OSC        16'hFFF9

// ****************************************
// Current reference sources and setpoint range
// ****************************************
`define OMS_REF_NONE        16'h0000
`define OMS_REF_ANALOGUE    16'h0001
`define OMS_REF_SETPOINT    16'h0002
`define OMS_CUR_MIN         16'h8AD0
`define OMS_CUR_MAX         16'h7530

// ****************************************
// Control word and status word fields
// ****************************************
`define OMS_CW_START_BIT    4
`define OMS_CW_MODE_LO      4
`define OMS_CW_MODE_HI      6
`define OMS_SW_PROC_END_BIT 14

`endif

// file: tb/oms_fieldbus_master.sv
`timescale 1ns/1ps

// ****************************************
// Fieldbus master model
// ****************************************
module oms_fieldbus_master (
    // Clock
    input  wire         core_clk,
    // Parameter port
    output logic        par_wr,
    output logic        par_rd,
    output logic [15:0] par_addr,
    output logic [15:0] par_wdata,
    input  wire  [15:0] par_rdata_q,
    input  wire         par_ack_q,
    input  wire         par_err_q,
    // Control word
    output logic [15:0] drive_control_word
);
    initial begin
        par_wr = 1'b0;
        par_rd = 1'b0;
        par_addr = 16'h0000;
        par_wdata = 16'h0000;
        drive_control_word = 16'h0000;
    end

    // Strobe is a one-cycle pulse; the answer is taken one edge after acceptance
    task automatic access(input logic rd, input logic [15:0] a, input logic [15:0] d,
                          output logic ack, output logic err, output logic [15:0] rdat);
        @(posedge core_clk);
        par_wr <= !rd;
        par_rd <= rd;
        par_addr <= a;
        par_wdata <= d;
        @(posedge core_clk);
        par_wr <= 1'b0;
        par_rd <= 1'b0;
        // Released lines flip so a stale word cannot pass for a live one
        par_addr <= ~a;
        par_wdata <= ~d;
        @(posedge core_clk);
        ack = par_ack_q;
        err = par_err_q;
        rdat = par_rdata_q;
    endtask

    task automatic set_cw(input logic [15:0] cw);
        @(posedge core_clk);
        drive_control_word <= cw;
    endtask
endmodule

// file: tb/oms_mode_start_assertions.sv
`timescale 1ns/1ps
`include "oms_consts.vh"

module oms_mode_start_assertions (
    // Clock and reset
    input wire        core_clk,
    input wire        reset,
    // Parameter port
    input wire        par_wr,
    input wire        par_rd,
    input wire [15:0] par_addr,
    input wire [15:0] par_wdata,
    input wire        par_ack_q,
    input wire        par_err_q,
    // Drive state
    input wire [15:0] drive_control_word,
    input wire        local_control,
    input wire        ready_to_start,
    input wire        init_ok,
    input wire        standstill,
    input wire        halt,
    // Mode outputs
    input wire [15:0] active_mode_q,
    input wire        mode_running_q,
    input wire        motion_go_q,
    input wire [2:0]  ctrl_mode_bits_q,
    input wire        process_end_q,
    input wire [15:0] current_setpoint_q,
    input wire [15:0] current_reference_source_q,
    input wire        use_analogue_input_one_q,
    input wire        use_setpoint_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    function automatic bit in_range(input logic [15:0] v);
        in_range = $signed(v) >= -30000 && $signed(v) <= 30000;
    endfunction

    // ****************************************
    // Mode select and parameter writes
    // ****************************************
    sequence s_wr_mode; par_wr && par_addr == `OMS_ADDR_MODE_SEL && !local_control; endsequence
    sequence s_accept; s_wr_mode ##1 (par_ack_q && !par_err_q); endsequence

    property p_ack; par_ack_q == $past(par_wr || par_rd); endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    property p_start;
        s_accept |-> active_mode_q == $past(par_wdata) && mode_running_q && !process_end_q;
    endproperty
    a_start: assert property (p_start) else $error("accepted mode did not start");
    property p_armed;
        s_accept |-> !motion_go_q || !(active_mode_q inside {16'h0001, 16'h0006});
    endproperty
    a_armed: assert property (p_armed) else $error("position mode moved on write");
    property p_busy;
        s_wr_mode ##0 (mode_running_q && par_wdata != active_mode_q
            && !(par_wdata inside {16'hfffd, 16'hfffc}
            && active_mode_q inside {16'hfffd, 16'hfffc}))
        |=> par_err_q && $stable(active_mode_q);
    endproperty
    a_busy: assert property (p_busy) else $error("mode swapped while active");
    property p_not_ready;
        s_wr_mode ##0 (!mode_running_q && !(ready_to_start && init_ok))
        |=> par_err_q && !mode_running_q;
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("mode started when not ready");
    property p_unlisted;
        s_wr_mode ##0 !(par_wdata inside {16'h0001, 16'h0003, 16'h0006, 16'hffff, 16'hfffe,
            16'hfffd, 16'hfffc, 16'hfff9}) |=> par_err_q && $stable(active_mode_q);
    endproperty
    a_unlisted: assert property (p_unlisted) else $error("unlisted mode code taken");
    property p_setpoint;
        par_wr && par_addr == `OMS_ADDR_CUR_SET |=> par_err_q != in_range($past(par_wdata))
            && current_setpoint_q == (in_range($past(par_wdata)) ? $past(par_wdata)
            : $past(current_setpoint_q));
    endproperty
    a_setpoint: assert property (p_setpoint) else $error("setpoint range handling wrong");
    property p_source;
        par_wr && par_addr == `OMS_ADDR_CUR_REF |=> par_err_q == ($past(par_wdata) > 16'h0002);
    endproperty
    a_source: assert property (p_source) else $error("source code check wrong");
    property p_decode;
        use_setpoint_q == ($past(current_reference_source_q) == 16'h0002)
            && use_analogue_input_one_q == ($past(current_reference_source_q) == 16'h0001);
    endproperty
    a_decode: assert property (p_decode) else $error("source decode wrong");

    // ****************************************
    // Motion and completion
    // ****************************************
    property p_go_cause;
        $rose(motion_go_q) && !local_control && active_mode_q inside {16'h0001, 16'h0006}
        |-> $past(drive_control_word[4]) || $past(drive_control_word[4], 2);
    endproperty
    a_go_cause: assert property (p_go_cause) else $error("motion without start bit");
    property p_bits;
        ctrl_mode_bits_q != 3'b000 |-> (mode_running_q || $past(mode_running_q))
            && active_mode_q inside {16'h0001, 16'h0006};
    endproperty
    a_bits: assert property (p_bits) else $error("mode bits passed in wrong mode");
    property p_stop; motion_go_q && halt |=> !motion_go_q; endproperty
    a_stop: assert property (p_stop) else $error("motion kept after halt");
    property p_end; $rose(process_end_q) |-> $past(standstill); endproperty
    a_end: assert property (p_end) else $error("process end before standstill");
endmodule

bind oms_mode_start oms_mode_start_assertions i_chk (.*);

// file: tb/oms_mode_start_tb.sv
`timescale 1ns/1ps
`include "oms_consts.vh"

module oms_mode_start_tb;
    logic        core_clk, reset, local_control, enable_pin, hmi_jog_req, hmi_tune_req;
    logic        ready_to_start, init_ok, standstill, target_reached, quick_stop, halt, fault;
    logic [15:0] local_default_mode;
    wire         par_wr, par_rd, par_ack_q, par_err_q, mode_running_q, motion_go_q;
    wire         motor_energise_q, autotune_run_q, process_end_q;
    wire         use_analogue_input_one_q, use_setpoint_q;
    wire  [15:0] par_addr, par_wdata, drive_control_word, par_rdata_q, active_mode_q;
    wire  [15:0] current_setpoint_q, current_reference_source_q;
    wire  [2:0]  ctrl_mode_bits_q;
    integer      num_errors = 0;
    integer      comparisons = 0;
    logic        ack, err;
    logic [15:0] rdat;

    oms_mode_start i_dut (.*);
    oms_fieldbus_master i_bus (.*);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input integer n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
        i_bus.access(1'b0, a, d, ack, err, rdat);
        check("ack", ack, 1'b1);
        check("err", err, e);
    endtask

    task automatic rdv(input logic [15:0] a, input logic [15:0] e);
        i_bus.access(1'b1, a, 16'h0000, ack, err, rdat);
        check("rdata", rdat, e);
    endtask

    // Stop with halt, quick stop or target, then let the motor come to rest
    task automatic finish(input integer k);
        {target_reached, quick_stop, halt} <= 3'b001 << k;
        tick(1);
        {target_reached, quick_stop, halt} <= 3'b000;
        standstill <= 1'b1;
        tick(1);
        check("go", motion_go_q, 1'b0);
        tick(2);
        standstill <= 1'b0;
        check("running", mode_running_q, 1'b0);
        check("end", process_end_q, 1'b1);
    endtask

    task automatic t_local;
        check("end", process_end_q, 1'b1);
        rdv(`OMS_ADDR_CUR_SET, 16'h0000);
        rdv(`OMS_ADDR_CUR_REF, 16'h0000);
        init_ok <= 1'b1;
        tick(3);
        check("default", active_mode_q, 16'h0003);
        enable_pin <= 1'b1;
        tick(5);
        check("run", mode_running_q, 1'b1);
        check("power", motor_energise_q, 1'b1);
        enable_pin <= 1'b0;
        finish(0);
        hmi_jog_req <= 1'b1;
        tick(1);
        hmi_jog_req <= 1'b0;
        tick(2);
        check("jog", active_mode_q, 16'hffff);
        finish(0);
    endtask

    task automatic t_current;
        wr(`OMS_ADDR_CUR_SET, 16'h7531, 1'b1);
        wr(`OMS_ADDR_CUR_SET, 16'h8acf, 1'b1);
        wr(`OMS_ADDR_CUR_SET, 16'h8ad0, 1'b0);
        rdv(`OMS_ADDR_CUR_SET, 16'h8ad0);
        wr(`OMS_ADDR_CUR_REF, 16'h0003, 1'b1);
        wr(`OMS_ADDR_CUR_REF, 16'h0001, 1'b0);
        tick(1);
        check("analogue", use_analogue_input_one_q, 1'b1);
        wr(`OMS_ADDR_CUR_SET, 16'h7530, 1'b0);
        wr(`OMS_ADDR_CUR_REF, 16'h0002, 1'b0);
        wr(`OMS_ADDR_MODE_SEL, 16'hfffd, 1'b0);
        check("mode", active_mode_q, 16'hfffd);
        check("end", process_end_q, 1'b0);
        check("set", current_setpoint_q, 16'h7530);
        check("use set", use_setpoint_q, 1'b1);
        check("source", current_reference_source_q, 16'h0002);
        tick(1);
        check("power", motor_energise_q, 1'b1);
        wr(`OMS_ADDR_MODE_SEL, 16'h0003, 1'b1);
        check("mode", active_mode_q, 16'hfffd);
        wr(`OMS_ADDR_MODE_SEL, 16'hfffc, 1'b0);
        check("swap", active_mode_q, 16'hfffc);
        finish(0);
        wr(`OMS_ADDR_MODE_SEL, 16'h0003, 1'b0);
        finish(1);
    endtask

    task automatic t_modes;
        logic [15:0] codes [0:7];
        logic        ph;
        codes = '{16'h0001, 16'h0003, 16'h0006, 16'hffff, 16'hfffe, 16'hfffd, 16'hfffc, 16'hfff9};
        for (int i = 0; i < 8; i++) begin
            ph = codes[i] == 16'h0001 || codes[i] == 16'h0006;
            i_bus.set_cw(16'h0060);
            wr(`OMS_ADDR_MODE_SEL, codes[i], 1'b0);
            check("mode", active_mode_q, codes[i]);
            tick(1);
            check("bits", ctrl_mode_bits_q, ph ? 3'b110 : 3'b000);
            check("go", motion_go_q, !ph);
            if (ph) begin
                i_bus.set_cw(16'h0070);
                tick(3);
                check("go", motion_go_q, 1'b1);
            end
            finish(2);
        end
        i_bus.set_cw(16'h0000);
    endtask

    task automatic t_refuse_fault;
        wr(`OMS_ADDR_MODE_SEL, 16'h0002, 1'b1);
        check("mode", active_mode_q, 16'hfff9);
        ready_to_start <= 1'b0;
        wr(`OMS_ADDR_MODE_SEL, 16'h0003, 1'b1);
        check("running", mode_running_q, 1'b0);
        ready_to_start <= 1'b1;
        wr(16'h1234, 16'h0000, 1'b1);
        wr(`OMS_ADDR_MODE_SEL, 16'hfffc, 1'b0);
        fault <= 1'b1;
        tick(2);
        fault <= 1'b0;
        standstill <= 1'b1;
        tick(3);
        standstill <= 1'b0;
        check("end", process_end_q, 1'b1);
        wr(`OMS_ADDR_MODE_SEL, 16'hffff, 1'b0);
        check("mode", active_mode_q, 16'hffff);
        finish(0);
        i_bus.set_cw(16'h0010);
        tick(3);
        check("resume", mode_running_q, 1'b1);
        i_bus.set_cw(16'h0000);
        finish(1);
        local_control <= 1'b1;
        tick(2);
        hmi_tune_req <= 1'b1;
        tick(1);
        hmi_tune_req <= 1'b0;
        tick(2);
        check("tune", autotune_run_q, 1'b1);
        check("mode", active_mode_q, 16'hffff);
    endtask

    initial begin
        reset = 1'b1;
        {local_control, ready_to_start} = 2'b11;
        {init_ok, standstill, target_reached, quick_stop, halt, fault} = 6'h00;
        {enable_pin, hmi_jog_req, hmi_tune_req} = 3'b000;
        local_default_mode = 16'h0003;
        tick(3);
        reset <= 1'b0;
        tick(1);
        t_local();
        local_control <= 1'b0;
        t_current();
        t_modes();
        t_refuse_fault();
        close_out();
    end

    initial begin
        tick(20000);
        num_errors = num_errors + 1;
        close_out();
    end
endmodule

// file: verilog/oms_mode_start.v
`timescale 1ns/1ps
`include "oms_consts.vh"

module oms_mode_start (
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset,
    // Parameter port from the fieldbus
    input  wire        par_wr,
    input  wire        par_rd,
    input  wire [15:0] par_addr,
    input  wire [15:0] par_wdata,
    output reg  [15:0] par_rdata_q,
    output reg         par_ack_q,
    output reg         par_err_q,
    // Control word from the fieldbus
    input  wire [15:0] drive_control_word,
    // Local control
    input  wire        local_control,
    input  wire [15:0] local_default_mode,
    input  wire        enable_pin,
    input  wire        hmi_jog_req,
    input  wire        hmi_tune_req,
    // Drive state
    input  wire        ready_to_start,
    input  wire        init_ok,
    input  wire        standstill,
    input  wire        target_reached,
    input  wire        quick_stop,
    input  wire        halt,
    input  wire        fault,
    // Mode outputs
    output reg  [15:0] active_mode_q,
    output reg         mode_running_q,
    output reg         motion_go_q,
    output reg         motor_energise_q,
    output reg         autotune_run_q,
    output reg  [2:0]  ctrl_mode_bits_q,
    output reg         process_end_q,
    // Current control outputs
    output reg  [15:0] current_setpoint_q,
    output reg  [15:0] current_reference_source_q,
    output reg         use_analogue_input_one_q,
    output reg         use_setpoint_q
);

    // ****************************************
    // States
    // ****************************************
    localparam [2:0] ST_IDLE  = 3'b000;
    localparam [2:0] ST_ARM   = 3'b001;
    localparam [2:0] ST_RUN   = 3'b010;
    localparam [2:0] ST_STOP  = 3'b011;
    localparam [2:0] ST_FAULT = 3'b100;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [15:0] mode_d;
    reg         boot_done_q;
    reg         start_bit_q;
    reg         enable_q;
    reg         run_d;
    reg         go_d;
    reg         tune_d;
    reg         end_d;
    reg         rej_d;
    wire        enable_sync;
    wire        start_edge;
    wire        enable_rise;
    wire        enable_fall;
    wire        can_start;
    wire        wr_mode;
    wire        wr_ref;
    wire        wr_set;
    wire        code_ok;
    wire        set_ok;
    wire        ref_ok;
    wire        fast_swap;

    // Enable comes from a pin
    oms_sync2 u_enable_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (enable_pin),
        .sync_q   (enable_sync)
    );

    // ****************************************
    // Decode
    // ****************************************
    // Mode code decode
    function is_listed;
        input [15:0] c;
        begin
            is_listed = (c == `OMS_MODE_PROF_POS) || (c == `OMS_MODE_PROF_VEL) ||
                        (c == `OMS_MODE_HOMING)   || (c == `OMS_MODE_JOG)      ||
                        (c == `OMS_MODE_GEAR)     || (c == `OMS_MODE_CURRENT)  ||
                        (c == `OMS_MODE_SPEED)    || (c == `OMS_MODE_OSC);
        end
    endfunction

    function needs_trigger;
        input [15:0] c;
        begin
            needs_trigger = (c == `OMS_MODE_PROF_POS) || (c == `OMS_MODE_HOMING);
        end
    endfunction

    function is_cur_speed;
        input [15:0] c;
        begin
            is_cur_speed = (c == `OMS_MODE_CURRENT) || (c == `OMS_MODE_SPEED);
        end
    endfunction

    assign wr_mode = par_wr && (par_addr == `OMS_ADDR_MODE_SEL);
    assign wr_ref  = par_wr && (par_addr == `OMS_ADDR_CUR_REF);
    assign wr_set  = par_wr && (par_addr == `OMS_ADDR_CUR_SET);
    assign code_ok = is_listed(par_wdata);
    assign set_ok  = ($signed(par_wdata) >= $signed(`OMS_CUR_MIN)) &&
                     ($signed(par_wdata) <= $signed(`OMS_CUR_MAX));
    assign ref_ok  = (par_wdata <= `OMS_REF_SETPOINT);
    assign can_start = ready_to_start && init_ok && !fault;
    // Current and speed control may swap without standstill
    assign fast_swap = (state_q == ST_RUN) && is_cur_speed(active_mode_q) &&
                       is_cur_speed(par_wdata);
    assign start_edge  = drive_control_word[`OMS_CW_START_BIT] && !start_bit_q;
    assign enable_rise = enable_sync && !enable_q;
    assign enable_fall = !enable_sync && enable_q;

    // ****************************************
    // Mode sequencing
    // ****************************************
    always @* begin
        state_d = state_q;
        mode_d  = active_mode_q;
        run_d   = mode_running_q;
        go_d    = motion_go_q;
        tune_d  = autotune_run_q;
        end_d   = process_end_q;
        rej_d   = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (!local_control && wr_mode) begin
                    if (!code_ok || !can_start) begin
                        rej_d = 1'b1;
                    end else begin
                        mode_d  = par_wdata;
                        end_d   = 1'b0;
                        run_d   = 1'b1;
                        state_d = needs_trigger(par_wdata) ? ST_ARM : ST_RUN;
                        go_d    = !needs_trigger(par_wdata);
                    end
                end else if (local_control && can_start && hmi_jog_req) begin
                    mode_d  = `OMS_MODE_JOG;
                    end_d   = 1'b0;
                    run_d   = 1'b1;
                    go_d    = 1'b1;
                    state_d = ST_RUN;
                end else if (local_control && can_start && hmi_tune_req) begin
                    tune_d  = 1'b1;
                    end_d   = 1'b0;
                    run_d   = 1'b1;
                    go_d    = 1'b1;
                    state_d = ST_RUN;
                end else if (local_control && can_start && enable_rise &&
                             is_listed(active_mode_q)) begin
                    end_d   = 1'b0;
                    run_d   = 1'b1;
                    state_d = needs_trigger(active_mode_q) ? ST_ARM : ST_RUN;
                    go_d    = !needs_trigger(active_mode_q);
                end else if (!local_control && can_start && start_edge &&
                             is_listed(active_mode_q)) begin
                    end_d   = 1'b0;
                    run_d   = 1'b1;
                    go_d    = 1'b1;
                    state_d = ST_RUN;
                end
            end
            ST_ARM: begin
                // Nothing moving yet, but mode still active
                rej_d = wr_mode;
                if (fault) begin
                    state_d = ST_FAULT;
                end else if (quick_stop || halt || (local_control && enable_fall)) begin
                    state_d = ST_STOP;
                end else if (start_edge) begin
                    go_d    = 1'b1;
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                rej_d = wr_mode;
                if (fault) begin
                    state_d = ST_FAULT;
                    go_d    = 1'b0;
                end else if (quick_stop || halt || target_reached ||
                             (local_control && enable_fall)) begin
                    // Stop wins over a swap in the same cycle
                    go_d    = 1'b0;
                    state_d = ST_STOP;
                end else if (wr_mode && fast_swap) begin
                    rej_d  = 1'b0;
                    mode_d = par_wdata;
                end
            end
            ST_STOP: begin
                rej_d = wr_mode;
                if (fault) begin
                    state_d = ST_FAULT;
                end else if (standstill) begin
                    run_d   = 1'b0;
                    tune_d  = 1'b0;
                    end_d   = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_FAULT: begin
                go_d  = 1'b0;
                rej_d = wr_mode;
                // Leave once cause removed and stopped
                if (!fault && standstill) begin
                    run_d   = 1'b0;
                    tune_d  = 1'b0;
                    end_d   = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // State and mode registers
    // ****************************************
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q          <= ST_IDLE;
            active_mode_q    <= `OMS_RST_MODE;
            mode_running_q   <= 1'b0;
            motion_go_q      <= 1'b0;
            autotune_run_q   <= 1'b0;
            process_end_q    <= 1'b1;
            motor_energise_q <= 1'b0;
            boot_done_q      <= 1'b0;
            start_bit_q      <= 1'b0;
            enable_q         <= 1'b0;
            ctrl_mode_bits_q <= 3'b000;
        end else begin
            state_q        <= state_d;
            mode_running_q <= run_d;
            motion_go_q    <= go_d;
            autotune_run_q <= tune_d;
            process_end_q  <= end_d;
            start_bit_q    <= drive_control_word[`OMS_CW_START_BIT];
            enable_q       <= enable_sync;
            boot_done_q    <= boot_done_q || init_ok;
            if (local_control && init_ok && !boot_done_q) begin
                active_mode_q <= local_default_mode;
            end else if (local_control && state_q == ST_IDLE && standstill &&
                         !hmi_jog_req && boot_done_q &&
                         is_listed(local_default_mode)) begin
                active_mode_q <= local_default_mode;
            end else begin
                active_mode_q <= mode_d;
            end
            motor_energise_q <= local_control ? (enable_sync && can_start) :
                                (run_d && !fault);
            // Bits 4..6 only for position and homing
            if (needs_trigger(active_mode_q) && mode_running_q) begin
                ctrl_mode_bits_q <= drive_control_word[`OMS_CW_MODE_HI:`OMS_CW_MODE_LO];
            end else begin
                ctrl_mode_bits_q <= 3'b000;
            end
        end
    end

    // ****************************************
    // Parameter registers and read path
    // ****************************************
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            current_setpoint_q         <= `OMS_RST_CUR_SET;
            current_reference_source_q <= `OMS_RST_CUR_REF;
            use_analogue_input_one_q   <= 1'b0;
            use_setpoint_q             <= 1'b0;
            par_rdata_q                <= 16'h0000;
            par_ack_q                  <= 1'b0;
            par_err_q                  <= 1'b0;
        end else begin
            if (wr_set && set_ok) begin
                current_setpoint_q <= par_wdata;
            end
            if (wr_ref && ref_ok) begin
                current_reference_source_q <= par_wdata;
            end
            use_analogue_input_one_q <= (current_reference_source_q == `OMS_REF_ANALOGUE);
            use_setpoint_q           <= (current_reference_source_q == `OMS_REF_SETPOINT);
            par_ack_q <= par_wr || par_rd;
            par_err_q <= (wr_set && !set_ok) || (wr_ref && !ref_ok) || rej_d ||
                         (par_wr && !wr_mode && !wr_ref && !wr_set) ||
                         (par_rd && par_addr != `OMS_ADDR_MODE_SEL &&
                          par_addr != `OMS_ADDR_CUR_REF && par_addr != `OMS_ADDR_CUR_SET);
            if (par_rd) begin
                case (par_addr)
                    `OMS_ADDR_MODE_SEL: par_rdata_q <= active_mode_q;
                    `OMS_ADDR_CUR_REF:  par_rdata_q <= current_reference_source_q;
                    `OMS_ADDR_CUR_SET:  par_rdata_q <= current_setpoint_q;
                    default:            par_rdata_q <= 16'h0000;
                endcase
            end else begin
                par_rdata_q <= 16'h0000;
            end
        end
    end

endmodule

// file: verilog/oms_sync2.v
`timescale 1ns/1ps

// ****************************************
// Two-flop level synchroniser
// ****************************************
module oms_sync2 (
    // Clock and reset
    input  wire core_clk,
    input  wire reset,
    // Level in and out
    input  wire async_in,
    output reg  sync_q
);

    reg stage1_q;

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stage1_q <= 1'b0;
            sync_q   <= 1'b0;
        end else begin
            stage1_q <= async_in;
            sync_q   <= stage1_q;
        end
    end

endmodule
